//--- ptsc_pkg.sv
// ptsc_pkg: constants and carriers for position tracking and scaling
// assumes one 25 MHz system clock and settings held stable by software
//
// Notes on behaviour
// - tracking adds virtual turns, else encoder turns if multi-turn, else single-turn range
// - actual position confined to 32 bits
// - save position at power-off, read back at power-on
// - within quarter turn, rebuild from encoder value
// - outside window in positioner mode, raise fault
// - non-integer modulo ratio raises ratio fault
// - untracked ratio, 4096 factor for multi-turn only
// - tracked ratio uses virtual turns times units
// - units per load turn 1 to 2^31-1
// - gear load over motor turns, 1 to 2^20
// - positions expressed in length units
// - axis select: 0 linear, 1 modulo
// - modulo axis wraps at modulo range
// - load position derived from tracked encoder value
`default_nettype none

package ptsc_pkg;

  // ----------------------------------------------------------------
  // encoder and position widths
  // ----------------------------------------------------------------
  localparam int ST_BITS = 20;
  localparam int TURN_W = 12;
  localparam int POS_W = 32;
  localparam int UL_W = 52;
  localparam logic [ST_BITS-1:0] QUARTER_TURN = 20'h40000;
  localparam logic [1:0] TOP_QUAD = 2'h3;
  localparam logic [1:0] LOW_QUAD = 2'h0;

  // ----------------------------------------------------------------
  // setting ranges and defaults
  // ----------------------------------------------------------------
  localparam logic [30:0] UNITS_DEF = 31'h2710;
  localparam logic [20:0] GEAR_DEF = 21'h1;
  localparam logic [20:0] GEAR_MAX = 21'h100000;
  localparam logic [30:0] MOD_DEF = 31'h57e40;
  localparam logic [30:0] MOD_MAX = 31'h7ffffc17;
  localparam logic [TURN_W-1:0] VT_MIN = 12'h1;

  // ----------------------------------------------------------------
  // shared divider
  // ----------------------------------------------------------------
  localparam int DIV_NW = 96;
  localparam int DIV_DW = 64;
  localparam logic [6:0] DIV_LAST = 7'h5f;

  // ----------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tracking_enable;
    logic axis_type_select;
    logic [TURN_W-1:0] virtual_turns_setting;
    logic [30:0] modulo_range_setting;
    logic [30:0] units_per_load_turn;
    logic [20:0] gear_load_turns;
    logic [20:0] gear_motor_turns;
  } ptsc_cfg_s;

  typedef struct packed {
    logic [TURN_W-1:0] turns;
    logic [ST_BITS-1:0] st;
  } ptsc_nvrec_s;

  typedef enum logic [1:0] {PM_FETCH, PM_WAIT, PM_RUN} ptsc_mode_e;
  typedef enum logic [1:0] {PJ_SCALE, PJ_MOD, PJ_CHECK} ptsc_job_e;

endpackage

`default_nettype wire

//--- ptsc_div.sv
// ptsc_div: restoring divider, one quotient bit per clock
// assumes the caller never starts it with a zero divisor
`timescale 1ns/10ps
`default_nettype none

module ptsc_div (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // request
  input wire logic start_i,
  input wire logic [ptsc_pkg::DIV_NW-1:0] num_i,
  input wire logic [ptsc_pkg::DIV_DW-1:0] den_i,
  // result
  output logic busy_o,
  output logic done_o,
  output logic [ptsc_pkg::DIV_NW-1:0] quo_o,
  output logic [ptsc_pkg::DIV_DW-1:0] rem_o
);

  logic [ptsc_pkg::DIV_NW-1:0] quo_r;
  logic [ptsc_pkg::DIV_DW-1:0] rem_r;
  logic [ptsc_pkg::DIV_DW-1:0] den_r;
  logic [6:0] cnt_r;
  logic busy_r;
  logic done_r;
  wire logic [ptsc_pkg::DIV_DW:0] trial;
  wire logic [ptsc_pkg::DIV_DW:0] diff;
  wire logic ge;

  // ----------------------------------------------------------------
  // one step
  // ----------------------------------------------------------------
  assign trial = {rem_r, quo_r[ptsc_pkg::DIV_NW-1]};
  assign diff = trial - {1'b0, den_r};
  assign ge = ~diff[ptsc_pkg::DIV_DW];

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      quo_r <= '0;
      rem_r <= '0;
      den_r <= '0;
      cnt_r <= 7'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start_i && !busy_r) begin
        quo_r <= num_i;
        rem_r <= '0;
        den_r <= den_i;
        cnt_r <= 7'h0;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        quo_r <= {quo_r[ptsc_pkg::DIV_NW-2:0], ge};
        rem_r <= ge ? diff[ptsc_pkg::DIV_DW-1:0] :
          trial[ptsc_pkg::DIV_DW-1:0];
        cnt_r <= cnt_r + 7'h1;
        if (cnt_r == ptsc_pkg::DIV_LAST) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign busy_o = busy_r;
  assign done_o = done_r;
  assign quo_o = quo_r;
  assign rem_o = rem_r;

endmodule

`default_nettype wire

//--- ptsc_core.sv
// ptsc_core: virtual multi-turn tracking, restore check, unit scaling
// assumes encoder samples arrive on sys_clk_i; power_off_i is a raw pin
`timescale 1ns/10ps
`default_nettype none

module ptsc_core (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // settings
  input wire ptsc_pkg::ptsc_cfg_s cfg_i,
  input wire logic basic_positioner_mode_i,
  // encoder, same clock
  input wire logic enc_valid_i,
  input wire logic [ptsc_pkg::ST_BITS-1:0] enc_st_i,
  input wire logic [ptsc_pkg::TURN_W-1:0] enc_mt_i,
  input wire logic enc_is_multiturn_i,
  // power-fail pin
  input wire logic power_off_i,
  // retentive storage
  output logic nv_rd_o,
  input wire logic nv_rvalid_i,
  input wire ptsc_pkg::ptsc_nvrec_s nv_rdata_i,
  output logic nv_wr_o,
  output ptsc_pkg::ptsc_nvrec_s nv_wdata_o,
  // position and status
  output logic [ptsc_pkg::POS_W-1:0] actual_position_value_o,
  output logic restore_done_o,
  output logic tracking_tolerance_fault_o,
  output logic modulo_ratio_fault_o
);

  localparam int ST = ptsc_pkg::ST_BITS;
  localparam int TW = ptsc_pkg::TURN_W;

  ptsc_pkg::ptsc_mode_e mode_r;
  ptsc_pkg::ptsc_job_e job_r;
  logic [ST-1:0] st_r;
  logic [TW-1:0] mt_r, turn_r;
  logic [31:0] lu_r, actual_r;
  logic tol_fault_r, ratio_fault_r, nv_rd_r, nv_wr_r;
  ptsc_pkg::ptsc_nvrec_s nv_wdata_r;
  logic pf_s1_r, pf_s2_r, pf_s3_r, pf_r;

  // ----------------------------------------------------------------
  // settings held inside their ranges
  // ----------------------------------------------------------------
  wire logic [30:0] units_w, mod_w;
  wire logic [20:0] load_w, motor_w;
  wire logic [TW-1:0] vt_w;
  wire logic trk, modax;
  // zero is outside every range, so it falls back to the default
  assign units_w = (cfg_i.units_per_load_turn == 31'h0) ?
    ptsc_pkg::UNITS_DEF : cfg_i.units_per_load_turn;
  assign load_w = (cfg_i.gear_load_turns == 21'h0) ? ptsc_pkg::GEAR_DEF :
    (cfg_i.gear_load_turns > ptsc_pkg::GEAR_MAX) ? ptsc_pkg::GEAR_MAX :
    cfg_i.gear_load_turns;
  assign motor_w = (cfg_i.gear_motor_turns == 21'h0) ? ptsc_pkg::GEAR_DEF :
    (cfg_i.gear_motor_turns > ptsc_pkg::GEAR_MAX) ? ptsc_pkg::GEAR_MAX :
    cfg_i.gear_motor_turns;
  assign mod_w = (cfg_i.modulo_range_setting == 31'h0) ? ptsc_pkg::MOD_DEF :
    (cfg_i.modulo_range_setting > ptsc_pkg::MOD_MAX) ? ptsc_pkg::MOD_MAX :
    cfg_i.modulo_range_setting;
  assign vt_w = (cfg_i.virtual_turns_setting == 12'h0) ? ptsc_pkg::VT_MIN :
    cfg_i.virtual_turns_setting;
  assign trk = cfg_i.tracking_enable;
  assign modax = cfg_i.axis_type_select;

  // ----------------------------------------------------------------
  // turn stepping
  // ----------------------------------------------------------------
  function automatic logic [TW-1:0] turn_step(input logic [TW-1:0] t,
    input logic up, input logic dn, input logic [TW-1:0] vt);
    logic [TW-1:0] r;
    r = t;
    if (up) begin
      r = (t >= vt - 12'h1) ? 12'h0 : t + 12'h1;
    end else if (dn) begin
      r = (t == 12'h0 || t >= vt) ? vt - 12'h1 : t - 12'h1;
    end
    return r;
  endfunction
  // wrap seen as a jump between the top and bottom quarter
  wire logic wrap_up, wrap_dn, run_trk;
  assign wrap_up = st_r[ST-1 -: 2] == ptsc_pkg::TOP_QUAD &&
    enc_st_i[ST-1 -: 2] == ptsc_pkg::LOW_QUAD;
  assign wrap_dn = st_r[ST-1 -: 2] == ptsc_pkg::LOW_QUAD &&
    enc_st_i[ST-1 -: 2] == ptsc_pkg::TOP_QUAD;
  assign run_trk = mode_r == ptsc_pkg::PM_RUN && trk && enc_valid_i;

  // ----------------------------------------------------------------
  // power-on restore check
  // ----------------------------------------------------------------
  wire logic [ST-1:0] pdiff, pabs;
  wire logic in_win, cross_up, cross_dn, win_eval;
  wire logic [TW-1:0] rest_turn;
  assign pdiff = st_r - nv_rdata_i.st;
  assign pabs = pdiff[ST-1] ? ST'(~pdiff + 20'h1) : pdiff;
  assign in_win = pabs <= ptsc_pkg::QUARTER_TURN;
  assign cross_up = !pdiff[ST-1] && st_r < nv_rdata_i.st;
  assign cross_dn = pdiff[ST-1] && st_r > nv_rdata_i.st;
  assign win_eval = mode_r == ptsc_pkg::PM_WAIT && nv_rvalid_i;
  assign rest_turn = (nv_rdata_i.turns >= vt_w) ? 12'h0 : nv_rdata_i.turns;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mode_r <= ptsc_pkg::PM_FETCH;
      turn_r <= 12'h0;
      tol_fault_r <= 1'b0;
      nv_rd_r <= 1'b0;
    end else begin
      nv_rd_r <= 1'b0;
      case (mode_r)
        ptsc_pkg::PM_FETCH: begin
          // wait for a live encoder value before judging the saved one
          if (enc_valid_i) begin
            nv_rd_r <= trk;
            mode_r <= trk ? ptsc_pkg::PM_WAIT : ptsc_pkg::PM_RUN;
          end
        end
        ptsc_pkg::PM_WAIT: begin
          if (nv_rvalid_i) begin
            mode_r <= ptsc_pkg::PM_RUN;
            if (in_win) begin
              turn_r <= turn_step(rest_turn, cross_up, cross_dn, vt_w);
            end else begin
              turn_r <= rest_turn;
              tol_fault_r <= tol_fault_r | basic_positioner_mode_i;
            end
          end
        end
        ptsc_pkg::PM_RUN: begin
          if (run_trk) begin
            turn_r <= turn_step(turn_r, wrap_up, wrap_dn, vt_w);
          end
        end
        default: begin
          mode_r <= ptsc_pkg::PM_FETCH;
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_r <= '0;
      mt_r <= '0;
    end else if (enc_valid_i) begin
      st_r <= enc_st_i;
      mt_r <= enc_mt_i;
    end
  end

  // ----------------------------------------------------------------
  // power-fail pin and save
  // ----------------------------------------------------------------
  wire logic pf_agree, save_ev;
  wire ptsc_pkg::ptsc_nvrec_s cur_rec;
  assign pf_agree = pf_s2_r == pf_s3_r;
  assign save_ev = pf_agree && pf_s3_r && !pf_r &&
    mode_r == ptsc_pkg::PM_RUN && trk;
  assign cur_rec = '{turns: turn_r, st: st_r};
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pf_s1_r <= 1'b0;
      pf_s2_r <= 1'b0;
      pf_s3_r <= 1'b0;
      pf_r <= 1'b0;
      nv_wr_r <= 1'b0;
      nv_wdata_r <= '0;
    end else begin
      pf_s1_r <= power_off_i;
      pf_s2_r <= pf_s1_r;
      pf_s3_r <= pf_s2_r;
      pf_r <= pf_agree ? pf_s3_r : pf_r;
      nv_wr_r <= save_ev;
      nv_wdata_r <= save_ev ? cur_rec : nv_wdata_r;
    end
  end

  // ----------------------------------------------------------------
  // scaling, modulo wrap and ratio check on one divider
  // ----------------------------------------------------------------
  wire logic [31:0] raw_pos, lu_now;
  wire logic [ptsc_pkg::UL_W-1:0] ul, mm;
  wire logic [83:0] scale_num;
  wire logic [ptsc_pkg::DIV_NW-1:0] chk_num, dv_num, dv_quo;
  wire logic [ptsc_pkg::DIV_DW-1:0] chk_den, dv_den, dv_rem;
  wire logic dv_busy, dv_done, dv_start;
  // tracked value feeds the gear, so encoder overflow leaves no offset
  assign raw_pos = trk ? {turn_r, st_r} :
    enc_is_multiturn_i ? {mt_r, st_r} : {12'h0, st_r};
  assign ul = 52'(units_w) * 52'(load_w);
  assign mm = 52'(motor_w) * 52'(mod_w);
  assign scale_num = 84'(raw_pos) * 84'(ul);
  assign chk_num = trk ? 96'(43'(vt_w) * 43'(units_w)) :
    enc_is_multiturn_i ? 96'({ul, 12'h0}) : 96'(ul);
  assign chk_den = trk ? 64'(mod_w) : 64'(mm);
  assign dv_num = (job_r == ptsc_pkg::PJ_SCALE) ? 96'(scale_num) :
    (job_r == ptsc_pkg::PJ_MOD) ? 96'(lu_r) : chk_num;
  assign dv_den = (job_r == ptsc_pkg::PJ_SCALE) ? 64'(motor_w) :
    (job_r == ptsc_pkg::PJ_MOD) ? 64'(mod_w) : chk_den;
  // result kept to 32 bits, upper turns fall away
  assign lu_now = dv_quo[ST +: 32];
  assign dv_start = mode_r == ptsc_pkg::PM_RUN && !dv_busy && !dv_done;
  ptsc_div u_div (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .start_i(dv_start),
    .num_i(dv_num), .den_i(dv_den), .busy_o(dv_busy), .done_o(dv_done),
    .quo_o(dv_quo), .rem_o(dv_rem));
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      job_r <= ptsc_pkg::PJ_SCALE;
      lu_r <= 32'h0;
      actual_r <= 32'h0;
      ratio_fault_r <= 1'b0;
    end else if (dv_done) begin
      case (job_r)
        ptsc_pkg::PJ_SCALE: begin
          lu_r <= lu_now;
          actual_r <= modax ? actual_r : lu_now;
          job_r <= modax ? ptsc_pkg::PJ_MOD : ptsc_pkg::PJ_CHECK;
        end
        ptsc_pkg::PJ_MOD: begin
          actual_r <= dv_rem[31:0];
          job_r <= ptsc_pkg::PJ_CHECK;
        end
        ptsc_pkg::PJ_CHECK: begin
          ratio_fault_r <= modax && dv_rem != 64'h0;
          job_r <= ptsc_pkg::PJ_SCALE;
        end
        default: begin
          job_r <= ptsc_pkg::PJ_SCALE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign nv_rd_o = nv_rd_r;
  assign nv_wr_o = nv_wr_r;
  assign nv_wdata_o = nv_wdata_r;
  assign actual_position_value_o = actual_r;
  assign restore_done_o = mode_r == ptsc_pkg::PM_RUN;
  assign tracking_tolerance_fault_o = tol_fault_r;
  assign modulo_ratio_fault_o = ratio_fault_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  chk_save_write: assert property (
    save_ev |=> nv_wr_o && nv_wdata_o == $past(cur_rec) ##1 !nv_wr_o)
    else $error("power-off save not written");
  chk_restore_read: assert property (
    mode_r == ptsc_pkg::PM_FETCH && enc_valid_i && trk |=>
      nv_rd_o && mode_r == ptsc_pkg::PM_WAIT ##1 !nv_rd_o)
    else $error("restore read not issued");
  chk_tol_raise: assert property (
    win_eval && !in_win && basic_positioner_mode_i |=>
      tracking_tolerance_fault_o)
    else $error("tolerance fault missing");
  chk_tol_keep: assert property (
    win_eval && in_win |=> $stable(tracking_tolerance_fault_o))
    else $error("tolerance fault in window");
  chk_rebuild_turn: assert property (
    win_eval && in_win && !cross_up && !cross_dn |=>
      turn_r == $past(rest_turn) && restore_done_o)
    else $error("turn count not rebuilt");
  chk_turn_up: assert property (
    run_trk && wrap_up && turn_r < vt_w - 12'h1 |=>
      turn_r == $past(turn_r) + 12'h1)
    else $error("turn count not advanced");
  chk_turn_wrap: assert property (
    run_trk && wrap_up && turn_r == vt_w - 12'h1 |=> turn_r == 12'h0)
    else $error("turn count not wrapped");
  chk_linear_out: assert property (
    dv_done && job_r == ptsc_pkg::PJ_SCALE && !modax |=>
      actual_position_value_o == $past(lu_now))
    else $error("linear position not updated");
  chk_mod_range: assert property (
    dv_done && job_r == ptsc_pkg::PJ_MOD |=>
      actual_position_value_o < 32'($past(mod_w)))
    else $error("modulo position out of range");
  chk_ratio_flag: assert property (
    dv_done && job_r == ptsc_pkg::PJ_CHECK |=>
      modulo_ratio_fault_o == ($past(modax) && $past(dv_rem) != 64'h0))
    else $error("ratio fault wrong");
  chk_gear_range: assert property (
    load_w != 21'h0 && load_w <= ptsc_pkg::GEAR_MAX &&
      motor_w != 21'h0 && units_w != 31'h0)
    else $error("setting outside range");

endmodule

`default_nettype wire

//--- ptsc_enc_model.sv
// ptsc_enc_model: absolute encoder plus retentive record store
// assumes the bench sets the mechanical position on tgt_i
`timescale 1ns/10ps
`default_nettype none

module ptsc_enc_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // mechanics and store preload from the bench
  input wire logic [31:0] tgt_i,
  input wire logic [3:0] lat_i,
  input wire logic preset_i,
  input wire ptsc_pkg::ptsc_nvrec_s preset_rec_i,
  // encoder side
  output var logic enc_valid_o,
  output var logic [ptsc_pkg::ST_BITS-1:0] enc_st_o,
  output var logic [ptsc_pkg::TURN_W-1:0] enc_mt_o,
  // retentive store side
  input wire logic nv_rd_i,
  output var logic nv_rvalid_o,
  output var ptsc_pkg::ptsc_nvrec_s nv_rdata_o,
  input wire logic nv_wr_i,
  input wire ptsc_pkg::ptsc_nvrec_s nv_wdata_i
);
  // ----------
  // state
  // ----------
  ptsc_pkg::ptsc_nvrec_s store_r;
  logic [3:0] wait_r;
  logic pend_r;
  logic fire;

  assign fire = pend_r && (wait_r == 4'h0);

  // ----------
  // encoder: samples every other cycle
  // ----------
  // position only moves when the bench moves it, brake held
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      enc_valid_o <= 1'b0;
    end else begin
      enc_valid_o <= ~enc_valid_o;
    end
    // off-valid cycles show inverted data, never a stale copy
    enc_st_o <= enc_valid_o ? ~tgt_i[19:0] : tgt_i[19:0];
    enc_mt_o <= enc_valid_o ? ~tgt_i[31:20] : tgt_i[31:20];
  end

  // ----------
  // retentive store: survives reset, slow answer
  // ----------
  always_ff @(posedge sys_clk_i) begin
    if (preset_i) begin
      store_r <= preset_rec_i;
    end else if (nv_wr_i) begin
      store_r <= nv_wdata_i;
    end
    if (srst_i) begin
      pend_r <= 1'b0;
    end else if (nv_rd_i) begin
      pend_r <= 1'b1;
    end else if (fire) begin
      pend_r <= 1'b0;
    end
    wait_r <= nv_rd_i ? lat_i : wait_r - {3'h0, wait_r != 4'h0};
    nv_rvalid_o <= fire && !srst_i && !nv_rd_i;
    nv_rdata_o <= fire ? store_r : (srst_i ? '0 : ~nv_rdata_o);
  end
endmodule

`default_nettype wire

//--- tb_top.sv
// tb_top: self-checking bench for ptsc_core
// assumes the design carries its own assertions
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  // ----------
  // signals
  // ----------
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  ptsc_pkg::ptsc_cfg_s cfg = '0;
  ptsc_pkg::ptsc_cfg_s c = '0;
  ptsc_pkg::ptsc_nvrec_s prec = '0;
  ptsc_pkg::ptsc_nvrec_s rdat, wdat;
  logic bpm = 1'b0, pwr = 1'b0, mtf = 1'b0, pre = 1'b0;
  logic [31:0] tgt = '0;
  logic [31:0] pos;
  logic [31:0] xp;
  logic [3:0] lat = 4'h0;
  logic ev, rd, rv, wr, done, tf, rf;
  logic [19:0] est;
  logic [11:0] emt;
  int fail_count = 0, n_checks = 0, cyc = 0, rd_n = 0, wr_n = 0;
  // restore cases: saved record, encoder, turns, mode, fault
  logic [31:0] rs_rec [8] = '{32'h00510000, 32'h005ff000, 32'h00501000,
    32'h00500000, 32'h00500000, 32'h00500000, 32'h02030000, 32'h017ff000};
  logic [19:0] rs_st [8] = '{20'h20000, 20'h01000, 20'hff000, 20'h40000,
    20'h40001, 20'h70000, 20'h30000, 20'h01000};
  logic [11:0] rs_t [8] = '{12'h5, 12'h6, 12'h4, 12'h5, 12'h5, 12'h5,
    12'h0, 12'h0};
  logic [7:0] rs_b = 8'hdf;
  logic [7:0] rs_f = 8'h10;

  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  ptsc_core dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .cfg_i(cfg),
    .basic_positioner_mode_i(bpm), .enc_valid_i(ev), .enc_st_i(est),
    .enc_mt_i(emt), .enc_is_multiturn_i(mtf), .power_off_i(pwr),
    .nv_rd_o(rd), .nv_rvalid_i(rv), .nv_rdata_i(rdat), .nv_wr_o(wr),
    .nv_wdata_o(wdat), .actual_position_value_o(pos),
    .restore_done_o(done), .tracking_tolerance_fault_o(tf),
    .modulo_ratio_fault_o(rf));

  ptsc_enc_model far (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .tgt_i(tgt), .lat_i(lat), .preset_i(pre), .preset_rec_i(prec),
    .enc_valid_o(ev), .enc_st_o(est), .enc_mt_o(emt), .nv_rd_i(rd),
    .nv_rvalid_o(rv), .nv_rdata_o(rdat), .nv_wr_i(wr), .nv_wdata_i(wdat));

  // ----------
  // counters and hang guard
  // ----------
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (srst_i) begin
      rd_n <= 0;
      wr_n <= 0;
    end else begin
      if (rd === 1'b1) rd_n <= rd_n + 1;
      if (wr === 1'b1) wr_n <= wr_n + 1;
    end
  end

  always @(posedge sys_clk_i) begin
    if (cyc == 30000) begin
      fail_count++;
      close_out();
    end
  end

  // ----------
  // expectations
  // ----------
  function automatic logic [31:0] exp_pos(input logic [31:0] raw);
    logic [95:0] p;
    p = 96'(raw) * 96'(c.units_per_load_turn) * 96'(c.gear_load_turns);
    p = p / 96'(c.gear_motor_turns);
    p = {64'h0, p[51:20]};
    if (c.axis_type_select)
      p = p % 96'(c.modulo_range_setting);
    return p[31:0];
  endfunction

  function automatic logic exp_rf(input logic m);
    logic [95:0] n, d;
    if (c.tracking_enable) begin
      n = 96'(c.virtual_turns_setting) * 96'(c.units_per_load_turn);
      d = 96'(c.modulo_range_setting);
    end else begin
      n = (m ? 96'h1000 : 96'h1) * 96'(c.units_per_load_turn);
      n = n * 96'(c.gear_load_turns);
      d = 96'(c.gear_motor_turns) * 96'(c.modulo_range_setting);
    end
    return c.axis_type_select && (n % d != 96'h0);
  endfunction

  function automatic ptsc_pkg::ptsc_cfg_s rnd_cfg();
    ptsc_pkg::ptsc_cfg_s r;
    r = '0;
    // no dependent monitor settings live here to scale along
    r.units_per_load_turn = 31'($urandom % 32'h7fffffff + 1);
    r.gear_load_turns = 21'($urandom % 32'h100000 + 1);
    r.gear_motor_turns = 21'($urandom % 32'h100000 + 1);
    r.modulo_range_setting = 31'($urandom % 32'h7ffffc17 + 1);
    r.virtual_turns_setting = 12'h18;
    return r;
  endfunction

  // ----------
  // tasks
  // ----------
  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // settings change only in reset; bench redoes adjustment afterwards
  task automatic boot(input logic [31:0] t, input logic [31:0] r,
      input logic ld, input logic b, input logic m);
    int n;
    @(negedge sys_clk_i);
    srst_i = 1'b1;
    cfg = c;
    tgt = t;
    prec = r;
    pre = ld;
    bpm = b;
    mtf = m;
    pwr = 1'b0;
    lat = 4'($urandom % 8);
    @(negedge sys_clk_i);
    pre = 1'b0;
    srst_i = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk("restore_wait", n < 40, 1);
    chk("nv_reads", rd_n, c.tracking_enable);
    repeat (400) @(negedge sys_clk_i);
  endtask

  // ----------
  // scenarios
  // ----------
  initial begin
    void'($urandom(44));
    repeat (20) @(negedge sys_clk_i);
    // untracked, odd runs modulo; first four hand-picked ratios
    for (int i = 0; i < 8; i++) begin
      c = rnd_cfg();
      c.axis_type_select = i[0];
      if (i < 4) begin
        c.units_per_load_turn = 31'h8ca0;
        c.gear_load_turns = 21'h1;
        c.gear_motor_turns = 21'h3;
        c.modulo_range_setting = i[1] ? 31'h57e40 : 31'h2ee0;
      end
      boot($urandom, 32'h0, 1'b0, 1'b0, i[1]);
      xp = exp_pos(mtf ? tgt : {12'h0, tgt[19:0]});
      chk("position", pos, xp);
      chk("ratio_fault", rf, exp_rf(mtf));
    end
    @(negedge sys_clk_i) pwr = 1'b1;
    repeat (10) @(negedge sys_clk_i);
    chk("untracked_save", wr_n, 0);
    // restore window, zero crossing and turn limit
    for (int i = 0; i < 8; i++) begin
      c = rnd_cfg();
      c.tracking_enable = 1'b1;
      boot({12'h0, rs_st[i]}, rs_rec[i], 1'b1, rs_b[i], 1'b0);
      chk("tol_fault", tf, rs_f[i]);
      chk("restored", pos, exp_pos({rs_t[i], rs_st[i]}));
    end
    // tracked modulo ratio, non-integer then integer
    for (int i = 0; i < 2; i++) begin
      c = rnd_cfg();
      c.tracking_enable = 1'b1;
      c.axis_type_select = 1'b1;
      c.units_per_load_turn = ptsc_pkg::UNITS_DEF;
      c.modulo_range_setting = ptsc_pkg::MOD_DEF;
      c.virtual_turns_setting = i ? 12'h24 : 12'h18;
      boot(32'h00030000, 32'h00330000, 1'b1, 1'b1, 1'b0);
      chk("trk_ratio", rf, exp_rf(1'b0));
      chk("trk_mod_pos", pos, exp_pos(32'h00330000));
    end
    // turn count steps and wraps at the top turn
    c = rnd_cfg();
    c.tracking_enable = 1'b1;
    boot(32'h000f0000, 32'h017f0000, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      @(negedge sys_clk_i) tgt = i[0] ? 32'h000f0000 : 32'h00010000;
      repeat (400) @(negedge sys_clk_i);
      xp = exp_pos(i[0] ? 32'h017f0000 : 32'h00010000);
      chk("turn_step", pos, xp);
    end
    @(negedge sys_clk_i) pwr = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    chk("save_count", wr_n, 1);
    chk("save_rec", wdat, 32'h00010000);
    repeat (8) @(negedge sys_clk_i);
    chk("save_once", wr_n, 1);
    // power back on from what was saved
    boot(32'h00018000, 32'h0, 1'b0, 1'b1, 1'b0);
    chk("reload", pos, exp_pos(32'h00018000));
    close_out();
  end
endmodule

`default_nettype wire
